// File: rtl/acp_ctrl.sv
// Purpose: compare, configuration and pin control registers
// Assumes: classic wishbone, one clock, sync reset
// Notes: converter core and port pins sit outside
`timescale 1ns/1ps
`default_nettype none
`include "acp_consts.svh"
module acp_ctrl
  import acp_pkg::*;
#(
  parameter int NPIN = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  input wire logic alt_clk_i,
  input wire logic async_clk_i,
  input wire logic [NPIN-1:0] port_out_i,
  input wire logic [NPIN-1:0] port_oe_i,
  input wire logic [NPIN-1:0] port_pull_i,
  input wire logic [NPIN-1:0] pad_in_i,
  output logic [NPIN-1:0] pad_out_o,
  output logic [NPIN-1:0] pad_oe_o,
  output logic [NPIN-1:0] pad_pull_o,
  output logic [NPIN-1:0] port_in_o,
  output logic [NPIN-1:0] analog_sel_o,
  output logic conv_tick_o,
  output logic low_power_o,
  output logic long_sample_o,
  output logic ten_bit_o,
  output logic [9:0] result_o,
  output logic result_upd_o,
  output logic match_o
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [2:0] div_limit(input logic [1:0] code);
    div_limit = 3'((4'h1 << code) - 4'h1);
  endfunction

  logic [7:0] cvh_r, cvl_r, cfg_r, pin_r;
  logic cmp_en_r, cmp_gt_r;
  logic [9:0] res_r;
  logic match_r, upd_r, mflag_r;
  logic ack_r;
  logic ten_r;
  logic [31:0] dat_r;
  logic half_r, alt_q_r, asy_q_r;
  logic [2:0] div_cnt_r;
  logic [2:0] div_cnt_nxt;
  logic tick_r;
  logic [NPIN-1:0] pout_r, poe_r, ppull_r, pin_in_r;

  wire req = cyc_i & stb_i & ~ack_r;
  wire wr0 = req & we_i & sel_i[0];
  wire hit_cvh = adr_i == `ACP_OFF_CVH;
  wire hit_cvl = adr_i == `ACP_OFF_CVL;
  wire hit_cfg = adr_i == `ACP_OFF_CFG;
  wire hit_pin = adr_i == `ACP_OFF_PIN;
  wire hit_cmp = adr_i == `ACP_OFF_CMP;
  wire hit_res = adr_i == `ACP_OFF_RES;

  // ----------------------------------------
  // configuration fields
  // ----------------------------------------
  wire acp_clksrc_t clk_src = acp_clksrc_t'(cfg_r[`ACP_CFG_CLK_HI:`ACP_CFG_CLK_LO]);
  wire acp_mode_t mode = acp_mode_t'(cfg_r[`ACP_CFG_MODE_HI:`ACP_CFG_MODE_LO]);
  wire [1:0] div_code = cfg_r[`ACP_CFG_DIV_HI:`ACP_CFG_DIV_LO];
  wire is10 = mode == ACP_MODE_10;

  // ----------------------------------------
  // compare
  // ----------------------------------------
  wire [9:0] cmp_val = is10 ? {cvh_r[1:0], cvl_r} : {2'h0, cvl_r};
  wire [9:0] cmp_dat = is10 ? conv_data_i : {2'h0, conv_data_i[7:0]};
  wire below = cmp_dat < cmp_val;
  wire cond = cmp_gt_r ? ~below : below;
  wire take = conv_done_i & (~cmp_en_r | cond);

  // ----------------------------------------
  // converter clock source and divider
  // ----------------------------------------
  wire alt_rise = alt_clk_i & ~alt_q_r;
  wire asy_rise = async_clk_i & ~asy_q_r;
  wire src_tick = (clk_src == ACP_CLK_BUS) ? 1'b1 :
                  (clk_src == ACP_CLK_BUS2) ? half_r :
                  (clk_src == ACP_CLK_ALT) ? alt_rise : asy_rise;
  wire div_end = div_cnt_r >= div_limit(div_code);
  assign div_cnt_nxt = !src_tick ? div_cnt_r : div_end ? 3'h0 : div_cnt_r + 3'h1;

  // ----------------------------------------
  // register file and bus answer
  // ----------------------------------------
  wire [31:0] rd_mux =
    hit_cvh ? {24'h0, cvh_r & `ACP_CVH_MASK} :
    hit_cvl ? {24'h0, cvl_r} :
    hit_cfg ? {24'h0, cfg_r} :
    hit_pin ? {24'h0, pin_r} :
    hit_cmp ? {30'h0, cmp_gt_r, cmp_en_r} :
    hit_res ? {15'h0, mflag_r, 6'h0, res_r} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= req;
      dat_r <= req ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cvh_r <= `ACP_RST_BYTE;
      cvl_r <= `ACP_RST_BYTE;
      cfg_r <= `ACP_RST_BYTE;
      pin_r <= `ACP_RST_BYTE;
      ten_r <= 1'b0;
      cmp_en_r <= 1'b0;
      cmp_gt_r <= 1'b0;
    end
    else if (wr0)
    begin
      if (hit_cvh)
        cvh_r <= dat_i[7:0] & `ACP_CVH_MASK;
      if (hit_cvl)
        cvl_r <= dat_i[7:0];
      if (hit_cfg)
      begin
        cfg_r <= dat_i[7:0];
        ten_r <= dat_i[`ACP_CFG_MODE_HI:`ACP_CFG_MODE_LO] == ACP_MODE_10;
      end
      if (hit_pin)
        pin_r <= dat_i[7:0];
      if (hit_cmp)
      begin
        cmp_en_r <= dat_i[`ACP_CMP_EN];
        cmp_gt_r <= dat_i[`ACP_CMP_GT];
      end
    end
  end

  // ----------------------------------------
  // result capture
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_r <= `ACP_RST_RES;
      upd_r <= 1'b0;
      match_r <= 1'b0;
      mflag_r <= 1'b0;
    end
    else
    begin
      if (take)
        res_r <= cmp_dat;
      upd_r <= take;
      match_r <= conv_done_i & cmp_en_r & cond;
      if (conv_done_i)
        mflag_r <= cmp_en_r & cond;
    end
  end

  // ----------------------------------------
  // clock divider
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      half_r <= 1'b0;
      alt_q_r <= 1'b0;
      asy_q_r <= 1'b0;
      div_cnt_r <= 3'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      half_r <= ~half_r;
      alt_q_r <= alt_clk_i;
      asy_q_r <= async_clk_i;
      div_cnt_r <= div_cnt_nxt;
      tick_r <= src_tick & div_end;
    end
  end

  // ----------------------------------------
  // pin control
  // ----------------------------------------
  for (genvar n = 0; n < NPIN; n++)
  begin : g_pin
    wire dis = pin_r[n];
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        pout_r[n] <= 1'b0;
        poe_r[n] <= 1'b0;
        ppull_r[n] <= 1'b0;
        pin_in_r[n] <= 1'b0;
      end
      else
      begin
        pout_r[n] <= port_out_i[n] & ~dis;
        poe_r[n] <= port_oe_i[n] & ~dis;
        ppull_r[n] <= port_pull_i[n] & ~dis;
        pin_in_r[n] <= pad_in_i[n] & ~dis;
      end
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign pad_out_o = pout_r;
  assign pad_oe_o = poe_r;
  assign pad_pull_o = ppull_r;
  assign port_in_o = pin_in_r;
  assign analog_sel_o = pin_r;
  assign conv_tick_o = tick_r;
  assign low_power_o = cfg_r[`ACP_CFG_LP];
  assign long_sample_o = cfg_r[`ACP_CFG_LS];
  assign ten_bit_o = ten_r;
  assign result_o = res_r;
  assign result_upd_o = upd_r;
  assign match_o = match_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_hi_zero;
    ##1 cvh_r[7:2] == 6'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("compare high upper bits set");

  property p_keep;
    conv_done_i && cmp_en_r && !cond |=> $stable(res_r) && !result_upd_o;
  endproperty
  a_keep: assert property (p_keep) else $error("result changed without match");

  property p_take;
    conv_done_i && !cmp_en_r && is10 |=> result_o == $past(conv_data_i) && result_upd_o;
  endproperty
  a_take: assert property (p_take) else $error("ten-bit result not taken");

  property p_eight;
    conv_done_i && !cmp_en_r && !is10 |=> result_o[9:8] == 2'h0;
  endproperty
  a_eight: assert property (p_eight) else $error("eight-bit result has high bits");

  property p_ge;
    conv_done_i && cmp_en_r && cmp_gt_r && cmp_dat == cmp_val |=> match_o;
  endproperty
  a_ge: assert property (p_ge) else $error("equal value missed in greater mode");

  property p_low;
    conv_done_i && cmp_en_r && !cmp_gt_r && conv_data_i[7:0] < cvl_r && !is10 |=> match_o;
  endproperty
  a_low: assert property (p_low) else $error("low byte compare missed");

  sequence s_pin_dis;
    pin_r[0] ##1 pin_r[0];
  endsequence
  property p_pin;
    s_pin_dis |-> !pad_oe_o[0] && !port_in_o[0] && !pad_pull_o[0];
  endproperty
  a_pin: assert property (p_pin) else $error("disabled pin still driven");

  property p_bus_tick;
    (clk_src == ACP_CLK_BUS && div_code == 2'h0 && $stable(cfg_r)) [*3] |-> conv_tick_o;
  endproperty
  a_bus_tick: assert property (p_bus_tick) else $error("undivided bus clock lost ticks");

  property p_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// File: rtl/acp_consts.svh
// Purpose: constants of the converter control block
// Assumes: word-aligned registers on a 32-bit wishbone
// Notes: definitions only
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ACP_OFF_CVH 6'h00
`define ACP_OFF_CVL 6'h04
`define ACP_OFF_CFG 6'h08
`define ACP_OFF_PIN 6'h0C
`define ACP_OFF_CMP 6'h10
`define ACP_OFF_RES 6'h14
// ----------------------------------------
// field positions
// ----------------------------------------
`define ACP_CFG_LP 7
`define ACP_CFG_DIV_HI 6
`define ACP_CFG_DIV_LO 5
`define ACP_CFG_LS 4
`define ACP_CFG_MODE_HI 3
`define ACP_CFG_MODE_LO 2
`define ACP_CFG_CLK_HI 1
`define ACP_CFG_CLK_LO 0
`define ACP_CMP_EN 0
`define ACP_CMP_GT 1
`define ACP_RES_MATCH 16
`define ACP_CVH_MASK 8'h03
// ----------------------------------------
// reset values
// ----------------------------------------
`define ACP_RST_BYTE 8'h00
`define ACP_RST_RES 10'h000
`endif

// File: rtl/acp_pkg.sv
// Purpose: types of the converter control block
// Assumes: nothing
// Notes: encodings follow the field codes
package acp_pkg;
  typedef enum logic [1:0] {
    ACP_CLK_BUS = 2'h0,
    ACP_CLK_BUS2 = 2'h1,
    ACP_CLK_ALT = 2'h2,
    ACP_CLK_ASYNC = 2'h3
  } acp_clksrc_t;
  typedef enum logic [1:0] {
    ACP_MODE_8 = 2'h0,
    ACP_MODE_R1 = 2'h1,
    ACP_MODE_10 = 2'h2,
    ACP_MODE_R3 = 2'h3
  } acp_mode_t;
endpackage

// File: bench/acp_core_model.sv
// Purpose: converter core and clock sources
// Assumes: one result per go pulse
// Notes: data line changes every cycle outside a result
`timescale 1ns/1ps
`default_nettype none
module acp_core_model
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [9:0] val_i,
  output logic done_o,
  output logic [9:0] data_o,
  output logic alt_o,
  output logic async_o
);
  logic [1:0] div_r = 2'h0;
  initial
  begin
    done_o = 1'b0;
    data_o = 10'h000;
  end
  // ----------------------------------------
  // result pulse and source clocks
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    div_r <= div_r + 2'h1;
    done_o <= go_i;
    data_o <= go_i ? val_i : ~data_o;
  end
  assign alt_o = div_r[0];
  assign async_o = div_r[1];
endmodule
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench of the converter control block
// Assumes: 20 MHz clock, sync reset
// Notes: register table first, then pins, compare and divider
`timescale 1ns/1ps
`default_nettype none
`include "acp_consts.svh"
module tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0;
  logic [5:0] adr_i = 0;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic [7:0] pout = 0, pin_v = 0, pad_out_o, pad_oe_o, pad_pull_o, port_in_o, analog_sel_o;
  logic [9:0] val = 0, cdata, result_o;
  logic ack_o, cdone, alt, asy, conv_tick_o, low_power_o, long_sample_o, ten_bit_o, result_upd_o, match_o;
  int num_errors = 0, checked = 0, cnt, e;
  // {we, adr, write data, expected read}
  logic [23:0] rows [0:15] = '{24'h000000, 24'h040000, 24'h080000, 24'h0C0000, 24'h100000, 24'h140000,
    24'h80FF00, 24'h000003, 24'h84A500, 24'h0400A5, 24'h88FF00, 24'h0800FF,
    24'h8C5A00, 24'h0C005A, 24'h98FF00, 24'h180000};
  acp_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conv_done_i(cdone), .conv_data_i(cdata),
    .alt_clk_i(alt), .async_clk_i(asy), .port_out_i(pout), .port_oe_i(pout), .port_pull_i(pout),
    .pad_in_i(pin_v), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pull_o(pad_pull_o),
    .port_in_o(port_in_o), .analog_sel_o(analog_sel_o), .conv_tick_o(conv_tick_o),
    .low_power_o(low_power_o), .long_sample_o(long_sample_o), .ten_bit_o(ten_bit_o),
    .result_o(result_o), .result_upd_o(result_upd_o), .match_o(match_o));
  acp_core_model i_core (.clk_i(clk_i), .go_i(go), .val_i(val), .done_o(cdone), .data_o(cdata),
    .alt_o(alt), .async_o(asy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
    chk(ack_o, 0);
  endtask
  task automatic conv(input logic [9:0] v, input logic m, input logic u, input logic [9:0] r);
    @(posedge clk_i);
    go <= 1;
    val <= v;
    @(posedge clk_i);
    go <= 0;
    @(posedge clk_i);
    #1;
    chk({match_o, result_upd_o}, {m, u});
    chk(result_o, r);
  endtask
  task automatic conclude();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    #1000000;
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 16; i++)
    begin
      wb(rows[i][23], rows[i][21:16], rows[i][15:8]);
      if (!rows[i][23]) chk(rd, {24'h0, rows[i][7:0]});
    end
    chk({low_power_o, long_sample_o, ten_bit_o}, 3'b110);
    @(posedge clk_i);
    pout <= 8'hFF;
    pin_v <= 8'hFF;
    repeat (2) @(posedge clk_i);
    #1 chk({pad_out_o, pad_oe_o, pad_pull_o, port_in_o}, 32'hA5A5A5A5);
    chk(analog_sel_o, 8'h5A);
    wb(1, `ACP_OFF_CVH, 8'h02);
    wb(1, `ACP_OFF_CVL, 8'h10);
    wb(1, `ACP_OFF_CFG, 8'h08);
    chk({low_power_o, long_sample_o, ten_bit_o}, 3'b001);
    wb(1, `ACP_OFF_CMP, 8'h00);
    conv(10'h3FF, 0, 1, 10'h3FF);
    wb(1, `ACP_OFF_CMP, 8'h01);
    conv(10'h20F, 1, 1, 10'h20F);
    conv(10'h210, 0, 0, 10'h20F);
    wb(1, `ACP_OFF_CMP, 8'h03);
    conv(10'h210, 1, 1, 10'h210);
    conv(10'h1FF, 0, 0, 10'h210);
    wb(1, `ACP_OFF_CFG, 8'h00);
    conv(10'h110, 1, 1, 10'h010);
    conv(10'h00F, 0, 0, 10'h010);
    wb(1, `ACP_OFF_CMP, 8'h01);
    conv(10'h30F, 1, 1, 10'h00F);
    wb(0, `ACP_OFF_RES, 8'h00);
    chk(rd, 32'h0001000F);
    wb(1, `ACP_OFF_CMP, 8'h00);
    conv(10'h3AB, 0, 1, 10'h0AB);
    sel_i <= 4'hE;
    wb(1, `ACP_OFF_CVL, 8'h77);
    sel_i <= 4'hF;
    wb(0, `ACP_OFF_CVL, 8'h00);
    chk(rd, 32'h00000010);
    for (int c = 0; c < 16; c++)
    begin
      wb(1, `ACP_OFF_CFG, {1'b0, c[1:0], 3'b000, c[3:2]});
      repeat (8) @(posedge clk_i);
      cnt = 0;
      repeat (128)
      begin
        @(posedge clk_i);
        if (conv_tick_o === 1'b1) cnt++;
      end
      e = 128 >> (c % 4 + (c / 4 == 3 ? 2 : (c / 4 > 0 ? 1 : 0)));
      chk(cnt + 1 >= e && cnt <= e + 1, 1);
    end
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    #1 chk({analog_sel_o, pad_oe_o, port_in_o}, 32'h0);
    chk({result_o, low_power_o, long_sample_o, ten_bit_o, conv_tick_o, match_o, result_upd_o}, 32'h0);
    wb(0, `ACP_OFF_PIN, 8'h00);
    chk(rd, 32'h0);
    wb(0, `ACP_OFF_RES, 8'h00);
    chk(rd, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
